// >>> pkg/bpsq_pkg.sv
// Constants, register map and state type for the buck protection sequencer.
// Assumes a 20 MHz control clock and comparator inputs synchronous to it.
package bpsq_pkg;

  // Timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int MIN_ON_NS        = 100;  // Unloaded figure, the longer one
  localparam int MIN_ON_LOADED_NS = 85;
  localparam int MIN_ON_CYC       = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_HIGH_MIN_NS = 75;
  localparam int SYNC_MIN_KHZ     = 300;
  localparam int SYNC_MAX_KHZ     = 2000;
  localparam int CL_HICCUP_CYCLES = 512;
  localparam int HICCUP_CYCLES    = 16000;

  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PREBIAS = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CLCNT   = 4'h4;

  // Fields
  localparam int CTRL_SYNC_BIT   = 0;
  localparam int ST_STATE_LSB    = 0;
  localparam int ST_PG_PIN_BIT   = 3;
  localparam int ST_REF_INT_BIT  = 4;
  localparam int ST_PREBIAS_BIT  = 5;
  localparam int ST_HS_BIT       = 6;
  localparam int ST_LS_BIT       = 7;
  localparam int PERIOD_W        = 8;

  // Reset values and limits
  localparam logic [DATA_W-1:0]   CTRL_RST    = 16'h0000;
  localparam logic [PERIOD_W-1:0] PERIOD_RST  = 8'h28;
  localparam logic [PERIOD_W-1:0] PERIOD_MIN  = 8'h0a;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX  = 8'h64;
  localparam logic [PERIOD_W-1:0] PREBIAS_RST = 8'h02;

  typedef enum logic [2:0] {
    BPSQ_OFF,
    BPSQ_DISCH,
    BPSQ_RUN,
    BPSQ_HICCUP,
    BPSQ_THERM
  } bpsq_state_e;

endpackage : bpsq_pkg

// >>> logic/bpsq_cycle_timer.sv
// Switching cycle timebase: internal period counter or external sync.
// Assumes the sync input is already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module bpsq_cycle_timer #(
  parameter int PERIOD_W = 8
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic                sync_sel_i,
  input  wire logic                sync_i,
  input  wire logic [PERIOD_W-1:0] period_i,
  output logic                     cycle_start_o
);

  logic                sync_d_reg;
  logic [PERIOD_W-1:0] cnt_reg;
  logic                start_reg;
  logic                sync_fall;
  logic                wrap;

  assign sync_fall     = sync_d_reg & ~sync_i;
  assign wrap          = (cnt_reg >= period_i - 1'b1);
  assign cycle_start_o = start_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_d_reg <= 1'b0;
    end else if (ce_i) begin
      sync_d_reg <= sync_i;
    end
  end

  // Rising switch node follows falling sync edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg   <= '0;
      start_reg <= 1'b0;
    end else if (ce_i) begin
      if (sync_sel_i) begin
        start_reg <= sync_fall;
        cnt_reg   <= '0;
      end else begin
        start_reg <= wrap;
        cnt_reg   <= wrap ? '0 : cnt_reg + 1'b1;
      end
    end
  end

endmodule : bpsq_cycle_timer

`default_nettype wire

// >>> logic/bpsq_sequencer.sv
// Buck converter cycle gating, protection and start-up sequencing.
// Assumes comparator inputs and sync pin synchronous to a 20 MHz clk_i.
//
// Contract
// - Peak current comparator ends high-side on-time and turns low-side on.
// - Count consecutive current-limit cycles; at 512 enter hiccup.
// - In hiccup, no switching for about 16000 switching cycles, then resume.
// - Low-side forward limit skips next high-side pulse, low-side stays on.
// - After forward limit clears, high-side returns at next cycle start.
// - Reverse limit turns low-side off at once; both off until next cycle.
// - Pre-biased start: brief low-side pulse each cycle until level reached.
// - High-side on-time never below minimum controllable on-time; thermal stop, disable and undervoltage still cut a pulse short.
// - With external sync, switch node rises on sync falling edge.
// - Range flag pulled low below 91% or above 105% of reference.
// - Range flag released only once feedback is within 93% to 103%.
// - Feedback above 105% keeps the high-side disabled.
// - High-side allowed again from next cycle once below threshold.
// - Junction above 170 C stops all switching.
// - Below 155 C restart power-up, discharging soft-start to 60 mV first.
// - Undervoltage, disable or thermal stop: discharge soft-start before restart.
// - Reference follows soft-start until above 90%, then internal reference.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module bpsq_sequencer #(
  parameter int CL_LIMIT   = bpsq_pkg::CL_HICCUP_CYCLES,
  parameter int HICCUP_LEN = bpsq_pkg::HICCUP_CYCLES
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  input  wire logic                        enable_i,
  input  wire logic                        vin_uvlo_i,
  input  wire logic                        peak_cur_cmp_i,
  input  wire logic                        hs_cur_limit_i,
  input  wire logic                        ls_fwd_limit_i,
  input  wire logic                        ls_rev_limit_i,
  input  wire logic                        fb_below_91_i,
  input  wire logic                        fb_above_105_i,
  input  wire logic                        fb_in_window_i,
  input  wire logic                        temp_above_170_i,
  input  wire logic                        temp_below_155_i,
  input  wire logic                        ss_below_60mv_i,
  input  wire logic                        ss_above_90pct_i,
  input  wire logic                        prebias_reached_i,
  input  wire logic                        timing_sync_input_i,
  input  wire logic                        output_in_range_flag_i,
  input  wire logic [bpsq_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [bpsq_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [bpsq_pkg::DATA_W-1:0] reg_rdata_o,
  output logic                             hs_on_o,
  output logic                             ls_on_o,
  output logic                             soft_start_ramp_discharge_o,
  output logic                             ref_internal_sel_o,
  output logic                             output_in_range_flag_o,
  output logic                             output_in_range_flag_oe_n_o,
  output logic                             hiccup_o,
  output logic                             thermal_o
);

  localparam int CL_W = $clog2(CL_LIMIT + 1);
  localparam int HC_W = $clog2(HICCUP_LEN + 1);
  localparam int ON_W = 4;
  localparam logic [ON_W-1:0] MIN_ON_M1 = ON_W'(bpsq_pkg::MIN_ON_CYC - 1);

  if (CL_LIMIT < 1 || CL_W > bpsq_pkg::DATA_W || HICCUP_LEN < 1
      || bpsq_pkg::MIN_ON_CYC >= (1 << ON_W)) begin : g_chk
    $error("bpsq_sequencer: unsupported parameter value");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  bpsq_pkg::bpsq_state_e state_reg;
  bpsq_pkg::bpsq_state_e state_next;

  logic [bpsq_pkg::DATA_W-1:0]   ctrl_reg;
  logic [bpsq_pkg::PERIOD_W-1:0] period_reg;
  logic [bpsq_pkg::PERIOD_W-1:0] pb_width_reg;
  logic [bpsq_pkg::DATA_W-1:0]   rdata_reg;
  logic [CL_W-1:0]               cl_cnt_reg;
  logic [HC_W-1:0]               hc_cnt_reg;
  logic [ON_W-1:0]               on_cnt_reg;
  logic [bpsq_pkg::PERIOD_W-1:0] pb_cnt_reg;
  logic                          hs_reg;
  logic                          ls_reg;
  logic                          rev_off_reg;
  logic                          fwd_hold_reg;
  logic                          cl_seen_reg;
  logic                          pb_active_reg;
  logic                          pg_low_reg;
  logic                          ref_int_reg;
  logic                          cycle_start;
  logic                          run;
  logic                          cl_hit;
  logic                          cl_trip;
  logic                          hc_done;
  logic                          hs_end;
  logic                          skip_hs;

  function automatic logic [bpsq_pkg::PERIOD_W-1:0] clamp_period(
    input logic [bpsq_pkg::PERIOD_W-1:0] v
  );
    if (v < bpsq_pkg::PERIOD_MIN) begin
      return bpsq_pkg::PERIOD_MIN;
    end else if (v > bpsq_pkg::PERIOD_MAX) begin
      return bpsq_pkg::PERIOD_MAX;
    end
    return v;
  endfunction : clamp_period

  ////////////////////////////////////////////////////////////////////////////
  // Timebase

  bpsq_cycle_timer #(
    .PERIOD_W (bpsq_pkg::PERIOD_W)
  ) u_timer (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ce_i          (ce_i),
    .sync_sel_i    (ctrl_reg[bpsq_pkg::CTRL_SYNC_BIT]),
    .sync_i        (timing_sync_input_i),
    .period_i      (period_reg),
    .cycle_start_o (cycle_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operating state

  assign run     = (state_reg == bpsq_pkg::BPSQ_RUN);
  assign cl_hit  = hs_reg & hs_cur_limit_i;
  assign cl_trip = run & cycle_start & cl_seen_reg
                   & (cl_cnt_reg == CL_W'(CL_LIMIT - 1));
  assign hc_done = cycle_start & (hc_cnt_reg == HC_W'(HICCUP_LEN - 1));

  always_comb begin
    state_next = state_reg;
    if (temp_above_170_i) begin
      state_next = bpsq_pkg::BPSQ_THERM;
    end else if (state_reg == bpsq_pkg::BPSQ_THERM) begin
      if (temp_below_155_i) begin
        state_next = bpsq_pkg::BPSQ_DISCH;
      end
    end else if (!enable_i || vin_uvlo_i) begin
      state_next = bpsq_pkg::BPSQ_OFF;
    end else begin
      unique case (state_reg)
        bpsq_pkg::BPSQ_OFF:    state_next = bpsq_pkg::BPSQ_DISCH;
        bpsq_pkg::BPSQ_DISCH: begin
          if (ss_below_60mv_i) begin
            state_next = bpsq_pkg::BPSQ_RUN;
          end
        end
        bpsq_pkg::BPSQ_RUN: begin
          if (cl_trip) begin
            state_next = bpsq_pkg::BPSQ_HICCUP;
          end
        end
        bpsq_pkg::BPSQ_HICCUP: begin
          if (hc_done) begin
            state_next = bpsq_pkg::BPSQ_RUN;
          end
        end
        bpsq_pkg::BPSQ_THERM:  state_next = bpsq_pkg::BPSQ_THERM;
        default:               state_next = bpsq_pkg::BPSQ_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= bpsq_pkg::BPSQ_OFF;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // Consecutive current-limit cycles, set wins over the cycle-start clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cl_seen_reg <= 1'b0;
      cl_cnt_reg  <= '0;
    end else if (ce_i) begin
      cl_seen_reg <= cycle_start ? cl_hit : (cl_seen_reg | cl_hit);
      if (!run) begin
        cl_cnt_reg <= '0;
      end else if (cycle_start) begin
        cl_cnt_reg <= cl_seen_reg ? cl_cnt_reg + 1'b1 : '0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hc_cnt_reg <= '0;
    end else if (ce_i) begin
      if (state_reg != bpsq_pkg::BPSQ_HICCUP) begin
        hc_cnt_reg <= '0;
      end else if (cycle_start) begin
        hc_cnt_reg <= hc_cnt_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-cycle switch gating

  // Hiccup entry starts no pulse that the state change would cut short
  assign skip_hs = fwd_hold_reg | ls_fwd_limit_i | fb_above_105_i
                   | cl_trip;
  assign hs_end  = (on_cnt_reg >= MIN_ON_M1)
                   & (peak_cur_cmp_i | hs_cur_limit_i | fb_above_105_i);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_reg        <= 1'b0;
      ls_reg        <= 1'b0;
      on_cnt_reg    <= '0;
      rev_off_reg   <= 1'b0;
      pb_active_reg <= 1'b0;
      pb_cnt_reg    <= '0;
    end else if (ce_i) begin
      if (!run) begin
        hs_reg        <= 1'b0;
        ls_reg        <= 1'b0;
        rev_off_reg   <= 1'b0;
        pb_active_reg <= 1'b0;
      end else if (cycle_start) begin
        rev_off_reg <= 1'b0;
        on_cnt_reg  <= '0;
        if (!prebias_reached_i) begin
          hs_reg        <= 1'b0;
          ls_reg        <= 1'b1;
          pb_active_reg <= 1'b1;
          pb_cnt_reg    <= pb_width_reg;
        end else if (skip_hs) begin
          hs_reg        <= 1'b0;
          ls_reg        <= ~ls_rev_limit_i;
          pb_active_reg <= 1'b0;
        end else begin
          hs_reg        <= 1'b1;
          ls_reg        <= 1'b0;
          pb_active_reg <= 1'b0;
        end
      end else if (hs_reg) begin
        if (on_cnt_reg != {ON_W{1'b1}}) begin
          on_cnt_reg <= on_cnt_reg + 1'b1;
        end
        if (hs_end) begin
          hs_reg <= 1'b0;
          ls_reg <= ~rev_off_reg & ~ls_rev_limit_i;
        end
      end else if (ls_reg) begin
        if (ls_rev_limit_i) begin
          ls_reg      <= 1'b0;
          rev_off_reg <= 1'b1;
        end else if (pb_active_reg) begin
          if (pb_cnt_reg <= 8'h01) begin
            ls_reg        <= 1'b0;
            pb_active_reg <= 1'b0;
          end
          pb_cnt_reg <= pb_cnt_reg - 1'b1;
        end
      end
    end
  end

  // Forward limit seen this cycle blocks the next high-side pulse
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fwd_hold_reg <= 1'b0;
    end else if (ce_i) begin
      fwd_hold_reg <= cycle_start ? 1'b0 : (fwd_hold_reg | (ls_reg & ls_fwd_limit_i));
    end
  end

  assign hs_on_o = hs_reg;
  assign ls_on_o = ls_reg & ~ls_rev_limit_i;

  ////////////////////////////////////////////////////////////////////////////
  // Range flag, reference and soft-start

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pg_low_reg <= 1'b1;
    end else if (ce_i) begin
      if (!run || fb_below_91_i || fb_above_105_i) begin
        pg_low_reg <= 1'b1;
      end else if (fb_in_window_i) begin
        pg_low_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_int_reg <= 1'b0;
    end else if (ce_i) begin
      if (!run && state_reg != bpsq_pkg::BPSQ_HICCUP) begin
        ref_int_reg <= 1'b0;
      end else if (ss_above_90pct_i) begin
        ref_int_reg <= 1'b1;
      end
    end
  end

  assign output_in_range_flag_o      = 1'b0;
  assign output_in_range_flag_oe_n_o = ~pg_low_reg;
  assign ref_internal_sel_o          = ref_int_reg;
  assign soft_start_ramp_discharge_o = (state_reg == bpsq_pkg::BPSQ_OFF)
                                       | (state_reg == bpsq_pkg::BPSQ_DISCH)
                                       | (state_reg == bpsq_pkg::BPSQ_THERM);
  assign hiccup_o                    = (state_reg == bpsq_pkg::BPSQ_HICCUP);
  assign thermal_o                   = (state_reg == bpsq_pkg::BPSQ_THERM);

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg     <= bpsq_pkg::CTRL_RST;
      period_reg   <= bpsq_pkg::PERIOD_RST;
      pb_width_reg <= bpsq_pkg::PREBIAS_RST;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == bpsq_pkg::ADDR_CTRL) begin
        ctrl_reg <= reg_wdata_i & 16'h0001;
      end
      if (reg_addr_i == bpsq_pkg::ADDR_PERIOD) begin
        period_reg <= clamp_period(reg_wdata_i[bpsq_pkg::PERIOD_W-1:0]);
      end
      if (reg_addr_i == bpsq_pkg::ADDR_PREBIAS) begin
        pb_width_reg <= reg_wdata_i[bpsq_pkg::PERIOD_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else if (ce_i) begin
      rdata_reg <= '0;
      if (reg_rd_i) begin
        case (reg_addr_i)
          bpsq_pkg::ADDR_CTRL:    rdata_reg <= ctrl_reg;
          bpsq_pkg::ADDR_PERIOD:  rdata_reg <= {8'h00, period_reg};
          bpsq_pkg::ADDR_PREBIAS: rdata_reg <= {8'h00, pb_width_reg};
          bpsq_pkg::ADDR_STATUS: begin
            rdata_reg[bpsq_pkg::ST_STATE_LSB +: 3] <= state_reg;
            rdata_reg[bpsq_pkg::ST_PG_PIN_BIT]     <= output_in_range_flag_i;
            rdata_reg[bpsq_pkg::ST_REF_INT_BIT]    <= ref_int_reg;
            rdata_reg[bpsq_pkg::ST_PREBIAS_BIT]    <= pb_active_reg;
            rdata_reg[bpsq_pkg::ST_HS_BIT]         <= hs_reg;
            rdata_reg[bpsq_pkg::ST_LS_BIT]         <= ls_reg;
          end
          bpsq_pkg::ADDR_CLCNT:   rdata_reg <= bpsq_pkg::DATA_W'(cl_cnt_reg);
          default:                rdata_reg <= '0;
        endcase
      end
    end
  end

  assign reg_rdata_o = rdata_reg;

endmodule : bpsq_sequencer

`default_nettype wire

// >>> verification/bpsq_sequencer_monitor.sv
// Port checker for the sequencer, bound into every instance.
// Assumes ce_i stays high and comparator inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none
module bpsq_sequencer_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic vin_uvlo_i,
  input wire logic peak_cur_cmp_i,
  input wire logic ls_rev_limit_i,
  input wire logic fb_below_91_i,
  input wire logic fb_above_105_i,
  input wire logic fb_in_window_i,
  input wire logic temp_above_170_i,
  input wire logic hs_on_o,
  input wire logic ls_on_o,
  input wire logic soft_start_ramp_discharge_o,
  input wire logic output_in_range_flag_o,
  input wire logic output_in_range_flag_oe_n_o,
  input wire logic hiccup_o,
  input wire logic thermal_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence hs_held_s;
    hs_on_o && $past(hs_on_o);
  endsequence
  sequence gates_off_s;
    !hs_on_o && !ls_on_o;
  endsequence
  peak_end_a: assert property (
    hs_held_s ##0 (peak_cur_cmp_i && enable_i && !vin_uvlo_i && !temp_above_170_i)
    |=> !hs_on_o && (ls_on_o || ls_rev_limit_i)) else $error("peak did not end high-side");
  min_on_a: assert property ($rose(hs_on_o) |=> hs_on_o || thermal_o ||
    soft_start_ramp_discharge_o) else $error("high-side pulse too short");
  gates_apart_a: assert property (!(hs_on_o && ls_on_o))
    else $error("both gates on");
  rev_kill_a: assert property (ls_rev_limit_i |-> !ls_on_o)
    else $error("low-side on during reverse limit");
  ovp_block_a: assert property (fb_above_105_i && !hs_on_o |=> !hs_on_o)
    else $error("high-side started in overvoltage");
  therm_stop_a: assert property (temp_above_170_i |=> thermal_o ##1 gates_off_s)
    else $error("switching in thermal stop");
  hiccup_quiet_a: assert property (hiccup_o && $past(hiccup_o) |-> gates_off_s)
    else $error("switching in hiccup");
  pg_low_a: assert property (fb_below_91_i || fb_above_105_i |=>
    !output_in_range_flag_oe_n_o && !output_in_range_flag_o) else $error("range flag not low");
  pg_hold_a: assert property (!output_in_range_flag_oe_n_o && !fb_in_window_i
    |=> !output_in_range_flag_oe_n_o) else $error("range flag released early");
  stop_a: assert property (!enable_i || vin_uvlo_i |=>
    soft_start_ramp_discharge_o ##1 gates_off_s) else $error("no stop on disable");
endmodule : bpsq_sequencer_monitor
bind bpsq_sequencer bpsq_sequencer_monitor i_bpsq_sequencer_monitor (
  .clk_i                       (clk_i),
  .rst_i                       (rst_i),
  .enable_i                    (enable_i),
  .vin_uvlo_i                  (vin_uvlo_i),
  .peak_cur_cmp_i              (peak_cur_cmp_i),
  .ls_rev_limit_i              (ls_rev_limit_i),
  .fb_below_91_i               (fb_below_91_i),
  .fb_above_105_i              (fb_above_105_i),
  .fb_in_window_i              (fb_in_window_i),
  .temp_above_170_i            (temp_above_170_i),
  .hs_on_o                     (hs_on_o),
  .ls_on_o                     (ls_on_o),
  .soft_start_ramp_discharge_o (soft_start_ramp_discharge_o),
  .output_in_range_flag_o      (output_in_range_flag_o),
  .output_in_range_flag_oe_n_o (output_in_range_flag_oe_n_o),
  .hiccup_o                    (hiccup_o),
  .thermal_o                   (thermal_o)
);
`default_nettype wire

// >>> verification/bpsq_power_stage_model.sv
// Power stage comparators and external sync clock source.
// Assumes the 20 MHz control clock; sync runs free at 1 MHz.
`timescale 1ns/1ps
`default_nettype none
module bpsq_power_stage_model (
  input  wire logic       clk_i,
  input  wire logic       hs_on_i,
  input  wire logic       limit_mode_i,
  input  wire logic [3:0] on_len_i,
  output logic            peak_cur_cmp_o,
  output logic            hs_cur_limit_o,
  output logic            timing_sync_input_o
);
  logic [3:0] on_cnt_reg   = 4'h0;
  logic [4:0] sync_cnt_reg = 5'h00;
  always_ff @(posedge clk_i) begin
    on_cnt_reg <= hs_on_i ? on_cnt_reg + 4'h1 : 4'h0;
  end
  // Switch current ramps while high-side conducts
  assign peak_cur_cmp_o = hs_on_i && (on_cnt_reg >= on_len_i);
  assign hs_cur_limit_o = peak_cur_cmp_o && limit_mode_i;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    sync_cnt_reg <= (sync_cnt_reg == 5'h13) ? 5'h00 : sync_cnt_reg + 5'h01;
  end
  assign timing_sync_input_o = (sync_cnt_reg < 5'h04);
endmodule : bpsq_power_stage_model
`default_nettype wire

// >>> verification/bpsq_sequencer_tb.sv
// Self-checking bench for the buck protection sequencer.
// Assumes the power stage model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module bpsq_sequencer_tb;
  localparam int CL_N  = 4;
  localparam int HIC_N = 20;
  localparam int PER   = 10;
  typedef struct packed {logic wr; logic [3:0] a; logic [15:0] d; logic [15:0] e;} bpsq_row_s;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, uvlo = 1'b0, fwd = 1'b0, rev = 1'b0, lim = 1'b0;
  logic below = 1'b0, above = 1'b0, win = 1'b0, hot = 1'b0, cool = 1'b0, ss90 = 1'b0;
  logic pre = 1'b0, wr = 1'b0, rd = 1'b0, sq, hq, hic_seen = 1'b0, ss60 = 1'b1;
  logic [3:0]  addr  = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, rv;
  logic hs, ls, disch, refi, pg, pg_oe_n, hic, therm, peak, hs_lim, sync;
  wire logic pg_pin = pg_oe_n ? 1'b1 : pg; // Pulled-up pin, next stage enable
  int mismatches = 0, samples_checked = 0, cycles = 0, k, n, nh, nl;
  bpsq_row_s rows [11] = '{'{1'b0, 4'h0, 16'h0000, 16'h0000}, '{1'b0, 4'h1, 16'h0000, 16'h0028},
    '{1'b0, 4'h2, 16'h0000, 16'h0002}, '{1'b0, 4'h4, 16'h0000, 16'h0000},
    '{1'b1, 4'hf, 16'hffff, 16'h0000}, '{1'b1, 4'h1, 16'h0005, 16'h000a},
    '{1'b1, 4'h1, 16'h00ff, 16'h0064}, '{1'b1, 4'h4, 16'h0007, 16'h0000},
    '{1'b1, 4'h2, 16'h0003, 16'h0003}, '{1'b1, 4'h1, 16'h000a, 16'h000a},
    '{1'b0, 4'h3, 16'h0000, 16'h0000}};

  bpsq_sequencer #(.CL_LIMIT(CL_N), .HICCUP_LEN(HIC_N)) i_bpsq_sequencer (
    .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .enable_i(en), .vin_uvlo_i(uvlo),
    .peak_cur_cmp_i(peak), .hs_cur_limit_i(hs_lim), .ls_fwd_limit_i(fwd), .ls_rev_limit_i(rev),
    .fb_below_91_i(below), .fb_above_105_i(above), .fb_in_window_i(win),
    .temp_above_170_i(hot), .temp_below_155_i(cool), .ss_below_60mv_i(ss60),
    .ss_above_90pct_i(ss90), .prebias_reached_i(pre), .timing_sync_input_i(sync),
    .output_in_range_flag_i(pg_pin), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .hs_on_o(hs), .ls_on_o(ls),
    .soft_start_ramp_discharge_o(disch), .ref_internal_sel_o(refi),
    .output_in_range_flag_o(pg), .output_in_range_flag_oe_n_o(pg_oe_n), .hiccup_o(hic),
    .thermal_o(therm));
  bpsq_power_stage_model i_bpsq_power_stage_model (.clk_i(clk), .hs_on_i(hs),
    .limit_mode_i(lim), .on_len_i(4'h3), .peak_cur_cmp_o(peak), .hs_cur_limit_o(hs_lim),
    .timing_sync_input_o(sync));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (hic === 1'b1) hic_seen = 1'b1;
    if (cycles == 6000) begin
      mismatches++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rreg
  task automatic watch(input int cyc, output int h, output int l);
    h = 0; l = 0;
    repeat (cyc) begin
      @(posedge clk);
      h += int'(hs); l += int'(ls);
    end
  endtask : watch
  task automatic waith(input logic v);
    for (int t = 0; t < 4 * PER && hs !== v; t++) @(posedge clk);
    chk("hs_wait", {15'h0, v}, {15'h0, hs});
  endtask : waith
  task automatic pulses(input int cnt);
    int seen = 0;
    logic q = 1'b1;
    for (int t = 0; t < 3 * PER * cnt && seen < cnt; t++) begin
      @(posedge clk);
      if (hs && !q) seen++;
      q = hs;
    end
  endtask : pulses
  task automatic summarize;
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    chk("reset_outs", 16'h0002, {11'h0, refi, hs, ls, disch, pg_oe_n});
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].wr) wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, rv);
      chk("reg", rows[i].e, rv);
    end
    en <= 1'b1;
    watch(3 * PER, nh, nl);
    chk("prebias", 16'h1, {15'h0, nh == 0 && nl >= 3 && nl <= 9});
    pre <= 1'b1;
    waith(1'b1);
    wreg(4'h0, 16'h0001);
    sq = 1'b0; hq = 1'b0; n = 0; k = 99;
    repeat (90) begin
      @(posedge clk);
      k = (sq && !sync) ? 0 : k + 1;
      if (hs && !hq && k < 20) begin
        n++;
        chk("sync_lag", 16'h1, {15'h0, k >= 1 && k <= 3});
      end
      sq = sync; hq = hs;
    end
    chk("sync_cnt", 16'h1, {15'h0, n >= 3});
    wreg(4'h0, 16'h0000);
    hic_seen = 1'b0;
    repeat (3) begin
      lim <= 1'b1; pulses(2); lim <= 1'b0; pulses(2);
    end
    chk("cl_clear", 16'h0, {15'h0, hic_seen});
    lim <= 1'b1;
    for (k = 0; k < (CL_N + 3) * PER && !hic; k++) @(posedge clk);
    chk("cl_hiccup", 16'h1, {15'h0, hic && k >= (CL_N - 2) * PER});
    lim <= 1'b0;
    for (k = 0; k < 2 * HIC_N * PER && hic; k++) @(posedge clk);
    chk("hiccup_len", 16'h1, {15'h0, k >= (HIC_N - 1) * PER && k <= (HIC_N + 1) * PER});
    above <= 1'b1;
    repeat (3) @(posedge clk);
    watch(3 * PER, nh, nl);
    chk("ovp_hs", 16'h0, nh[15:0]);
    above <= 1'b0;
    waith(1'b1);
    win <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pg_release", 16'h1, {15'h0, pg_oe_n});
    below <= 1'b1; win <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pg_low", 16'h0, {15'h0, pg_oe_n});
    chk("pin_low", 16'h0, {15'h0, pg_pin});
    below <= 1'b0;
    repeat (3) @(posedge clk);
    chk("pg_hyst", 16'h0, {15'h0, pg_oe_n});
    win <= 1'b1;
    waith(1'b1);
    waith(1'b0);
    fwd <= 1'b1;
    watch(2 * PER, nh, nl);
    chk("fwd_skip", 16'h1, {15'h0, nh == 0 && nl == 2 * PER});
    fwd <= 1'b0;
    waith(1'b1);
    waith(1'b0);
    rev <= 1'b1;
    @(posedge clk);
    rev <= 1'b0; n = 0;
    for (k = 0; k < 2 * PER && !hs; k++) begin
      @(posedge clk);
      n += int'(ls && !hs);
    end
    chk("rev_hold", 16'h0, n[15:0]);
    hot <= 1'b1;
    repeat (3) @(posedge clk);
    chk("therm", 16'h1, {15'h0, therm});
    hot <= 1'b0; cool <= 1'b1; ss60 <= 1'b0; n = 0;
    repeat (6) begin
      @(posedge clk);
      n += int'(disch && !therm);
    end
    cool <= 1'b0; ss60 <= 1'b1;
    chk("therm_disch", 16'h1, {15'h0, n == 5 && !therm});
    waith(1'b1);
    ss90 <= 1'b1;
    repeat (3) @(posedge clk);
    chk("ref_int", 16'h1, {15'h0, refi});
    en <= 1'b0;
    repeat (2) @(posedge clk);
    watch(2 * PER, nh, nl);
    chk("disable", 16'h2, {13'h0, refi, disch, nh > 0 || nl > 0});
    en <= 1'b1; uvlo <= 1'b1;
    watch(2 * PER, nh, nl);
    chk("uvlo", 16'h2, {14'h0, disch, nh > 0 || nl > 0});
    summarize();
  end
endmodule : bpsq_sequencer_tb
`default_nettype wire
